//--- rtl/lpc_pkg.sv
// package: register map, field layout and carrier types of the optical sublayer control block
package lpc_pkg;
    localparam logic [7:0]  LPC_OFF_CTRL     = 8'h00;
    localparam logic [7:0]  LPC_OFF_STATUS   = 8'h04;
    localparam logic [7:0]  LPC_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0]  LPC_OFF_IRQ_CLR  = 8'h0C;
    localparam logic [7:0]  LPC_OFF_IRQ_EN   = 8'h10;
    localparam logic [7:0]  LPC_OFF_IMPL     = 8'h14;

    // control register fields
    localparam int          LPC_CTRL_RESET_BIT   = 0;
    localparam int          LPC_CTRL_TXOFF_BIT   = 1;
    localparam int          LPC_CTRL_AUTOOFF_BIT = 2;
    localparam logic [2:0]  LPC_CTRL_RST_VAL     = 3'h4;

    // status register fields
    localparam int          LPC_ST_SIGDET_BIT  = 0;
    localparam int          LPC_ST_RXFLT_BIT   = 1;
    localparam int          LPC_ST_TXFLT_BIT   = 2;
    localparam int          LPC_ST_FAULT_BIT   = 3;
    localparam int          LPC_ST_TXOFF_BIT   = 4;

    // interrupt event bits
    localparam int          LPC_EV_SIG_UP   = 0;
    localparam int          LPC_EV_SIG_DN   = 1;
    localparam int          LPC_EV_RXFLT    = 2;
    localparam int          LPC_EV_TXFLT    = 3;
    localparam int          LPC_EV_W        = 4;

    // soft reset pulse length in cycles
    localparam logic [3:0]  LPC_SRST_CYCLES = 4'h8;

    typedef struct packed {
        logic sigdet;
        logic rx_fault;
        logic tx_fault;
        logic fault;
        logic tx_off;
    } lpc_status_s;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
    } lpc_aphase_s;
endpackage

//--- rtl/lpc_pmd_ctrl.sv
// optical sublayer control/status block with an AHB-Lite register slave
// Contract
// - management view follows the common serial sublayer register mapping.
// - every transmit bit goes to the optical output, one drives high power.
// - every received optical bit goes upward, high power reports one.
// - signal detect is presented upward continuously as a level.
// - global signal-detect status bit always equals current signal detect.
// - signal detect is FAIL when received average power is below threshold.
// - signal detect is OK for compliant input above stressed sensitivity.
// - no check of a valid coded signal before asserting signal detect.
// - no latency bound on signal detect following optical conditions.
// - management reset performs the sublayer reset.
// - overall fault is OR of receive, transmit and implementation faults.
// - global transmit disable switches the optical transmitter off.
// - transmit fault should also assert global transmit disable; the code does so only while control bit 2 (auto-off) is set.
// - transmit disable itself is not treated as a transmit fault.
// - global transmit disable is controlled by its management control bit.
// - transmit fault is exposed through the transmit-fault status bit.
// - receive fault is OR of inverted signal detect and implementation fault.
// - receive fault feeds the combined receive-fault status bit.
`timescale 1ns/1ns
module lpc_pmd_ctrl
    import lpc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        tx_bit,
    output logic             opt_tx_out,
    input  wire logic        opt_rx_in,
    output logic             rx_bit,
    input  wire logic        sigdet_comp,
    output logic             signal_detect,
    input  wire logic        tx_fault_impl,
    input  wire logic        rx_fault_impl,
    input  wire logic        other_fault_impl,
    output logic             sublayer_soft_reset,
    output logic             irq
);
    logic              sd_meta_q, sd_q;
    logic              txf_meta_q, txf_q;
    logic              rxf_meta_q, rxf_q;
    logic              of_meta_q, of_q;
    logic              sd_prev_q, rxf_prev_q, txf_prev_q;
    logic [2:0]        ctrl_q;
    logic [3:0]        srst_cnt_q, srst_run_q;
    logic [LPC_EV_W-1:0] ist_q, ien_q;
    lpc_aphase_s       ap_q;
    lpc_status_s       st;
    logic              tx_global_off;
    logic              rx_fault_flag, tx_fault_flag, sublayer_fault_summary;
    logic              global_sigdet_status;
    logic [LPC_EV_W-1:0] ev;
    logic              soft_rst;
    logic [31:0]       rd_d;

    function automatic logic [31:0] lpc_zx(input logic [LPC_EV_W-1:0] v);
        lpc_zx = {{(32-LPC_EV_W){1'b0}}, v};
    endfunction

    // write to one register, seen in its data phase
    function automatic logic lpc_wr_hit(input lpc_aphase_s ap, input logic [7:0] off);
        lpc_wr_hit = ap.sel && ap.write && (ap.addr == off);
    endfunction

    // two-stage synchronisers for off-domain inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd_meta_q  <= 1'b0;
            sd_q       <= 1'b0;
            txf_meta_q <= 1'b0;
            txf_q      <= 1'b0;
            rxf_meta_q <= 1'b0;
            rxf_q      <= 1'b0;
            of_meta_q  <= 1'b0;
            of_q       <= 1'b0;
        end else begin
            sd_meta_q  <= sigdet_comp;
            sd_q       <= sd_meta_q;
            txf_meta_q <= tx_fault_impl;
            txf_q      <= txf_meta_q;
            rxf_meta_q <= rx_fault_impl;
            rxf_q      <= rxf_meta_q;
            of_meta_q  <= other_fault_impl;
            of_q       <= of_meta_q;
        end
    end

    // comparator already encodes the power threshold and OMA decision
    assign global_sigdet_status = sd_q;
    assign rx_fault_flag = ~sd_q | rxf_q;
    assign tx_fault_flag = txf_q;
    assign sublayer_fault_summary = rx_fault_flag | tx_fault_flag | of_q;
    assign soft_rst = (srst_cnt_q != 4'h0);
    assign tx_global_off = ctrl_q[LPC_CTRL_TXOFF_BIT] | soft_rst
                         | (ctrl_q[LPC_CTRL_AUTOOFF_BIT] & tx_fault_flag);

    always_comb begin
        st.sigdet   = global_sigdet_status;
        st.rx_fault = rx_fault_flag;
        st.tx_fault = tx_fault_flag;
        st.fault    = sublayer_fault_summary;
        st.tx_off   = tx_global_off;
    end

    // datapath: direct polarity, forced dark while disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_tx_out    <= 1'b0;
            rx_bit        <= 1'b0;
            signal_detect <= 1'b0;
        end else begin
            opt_tx_out    <= tx_bit & ~tx_global_off;
            rx_bit        <= opt_rx_in;
            signal_detect <= sd_q;
        end
    end

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= '0;
        end else if (hready) begin
            ap_q.sel   <= hsel & htrans[1];
            ap_q.write <= hwrite;
            ap_q.addr  <= haddr[7:0];
        end
    end

    // control register and self-clearing soft reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q     <= LPC_CTRL_RST_VAL;
            srst_cnt_q <= 4'h0;
        end else if (soft_rst) begin
            srst_cnt_q <= srst_cnt_q - 4'h1;
            if (srst_cnt_q == 4'h1) begin
                ctrl_q <= LPC_CTRL_RST_VAL;
            end
        end else if (lpc_wr_hit(ap_q, LPC_OFF_CTRL)) begin
            ctrl_q <= hwdata[2:0];
            if (hwdata[LPC_CTRL_RESET_BIT]) begin
                srst_cnt_q <= LPC_SRST_CYCLES;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sublayer_soft_reset <= 1'b0;
        end else begin
            sublayer_soft_reset <= soft_rst;
        end
    end

    // interrupt events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd_prev_q  <= 1'b0;
            // rx fault idles high while signal detect is low, so no false edge after reset
            rxf_prev_q <= 1'b1;
            txf_prev_q <= 1'b0;
        end else begin
            sd_prev_q  <= sd_q;
            rxf_prev_q <= rx_fault_flag;
            txf_prev_q <= tx_fault_flag;
        end
    end

    always_comb begin
        ev = '0;
        ev[LPC_EV_SIG_UP] = sd_q & ~sd_prev_q;
        ev[LPC_EV_SIG_DN] = ~sd_q & sd_prev_q;
        ev[LPC_EV_RXFLT]  = rx_fault_flag & ~rxf_prev_q;
        ev[LPC_EV_TXFLT]  = tx_fault_flag & ~txf_prev_q;
    end

    // sticky status: set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ist_q <= '0;
        end else if (lpc_wr_hit(ap_q, LPC_OFF_IRQ_CLR)) begin
            ist_q <= (ist_q & ~hwdata[LPC_EV_W-1:0]) | ev;
        end else begin
            ist_q <= ist_q | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ien_q <= '0;
        end else if (lpc_wr_hit(ap_q, LPC_OFF_IRQ_EN)) begin
            ien_q <= hwdata[LPC_EV_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((ist_q | ev) & ien_q);
        end
    end

    // read mux on the address-phase haddr, registered at the edge that ends the address phase
    always_comb begin
        rd_d = 32'h0000_0000;
        case (haddr[7:0])
            LPC_OFF_CTRL:     rd_d = {29'h0000_0000, ctrl_q};
            LPC_OFF_STATUS:   rd_d = {27'h0000_0000, st.tx_off, st.fault, st.tx_fault, st.rx_fault, st.sigdet};
            LPC_OFF_IRQ_STAT: rd_d = lpc_zx(ist_q);
            LPC_OFF_IRQ_EN:   rd_d = lpc_zx(ien_q);
            LPC_OFF_IMPL:     rd_d = {29'h0000_0000, of_q, txf_q, rxf_q};
            default:          rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= rd_d;
            end
        end
    end

    AST_SIGDET_MIRROR: assert property (@(posedge hclk) disable iff (!hresetn)
        signal_detect == $past(sd_q)) else $error("signal detect output not mirroring sync value");
    AST_STATUS_SD: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(sd_q) |-> st.sigdet ##1 signal_detect) else $error("status bit misses signal detect");
    AST_RXFAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        !sd_q |-> rx_fault_flag && sublayer_fault_summary) else $error("rx fault not raised on lost signal");
    AST_FAULT_OR: assert property (@(posedge hclk) disable iff (!hresetn)
        (of_q || tx_fault_flag) |-> sublayer_fault_summary) else $error("fault summary not ORed");
    AST_TX_DARK: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_global_off |=> !opt_tx_out) else $error("transmitter lit while disabled");
    AST_TX_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
        (!tx_global_off && tx_bit) |=> opt_tx_out) else $error("transmit bit dropped");
    AST_RX_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> rx_bit == $past(opt_rx_in)) else $error("receive bit not forwarded");
    AST_AUTO_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_fault_flag && ctrl_q[LPC_CTRL_AUTOOFF_BIT]) |-> tx_global_off) else $error("fault did not disable tx");
    AST_SRST_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(soft_rst) |-> soft_rst [*8] ##1 !soft_rst) else $error("soft reset length wrong");
    AST_TXF_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
        st.tx_fault == txf_q) else $error("tx fault status bit wrong");

    // run length of the soft reset pulse at the pin, for its length check
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            srst_run_q <= 4'h0;
        end else if (sublayer_soft_reset) begin
            srst_run_q <= srst_run_q + 4'h1;
        end else begin
            srst_run_q <= 4'h0;
        end
    end

    AST_ZERO_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout)
        else $error("slave inserted a wait state");

    AST_RESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
        !hresp)
        else $error("slave answered with an error response");

    AST_READ_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans[1] && !hwrite)
        |=> (hrdata == $past(rd_d)))
        else $error("read data not loaded for the data phase");

    AST_READ_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !(hready && hsel && htrans[1] && !hwrite)
        |=> $stable(hrdata))
        else $error("read data changed without a read");

    AST_RXFLT_IMPL: assert property (@(posedge hclk) disable iff (!hresetn)
        rxf_q
        |-> rx_fault_flag)
        else $error("implementation rx fault not in rx fault");

    AST_RXFLT_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        (sd_q && !rxf_q)
        |-> !rx_fault_flag)
        else $error("rx fault raised with signal present");

    AST_FAULT_RX: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_fault_flag
        |-> sublayer_fault_summary)
        else $error("rx fault missing from fault summary");

    AST_FAULT_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        !(rx_fault_flag || tx_fault_flag || of_q)
        |-> !sublayer_fault_summary)
        else $error("fault summary raised with no fault");

    AST_TXOFF_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[LPC_CTRL_TXOFF_BIT]
        |-> tx_global_off)
        else $error("control bit did not disable tx");

    AST_TXF_NOT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_global_off && !txf_q)
        |-> !tx_fault_flag)
        else $error("tx disable reported as tx fault");

    AST_RXF_STATUS: assert property (@(posedge hclk) disable iff (!hresetn)
        !sd_q
        |-> st.rx_fault)
        else $error("rx fault status bit misses lost signal");

    AST_SRST_DARK: assert property (@(posedge hclk) disable iff (!hresetn)
        soft_rst
        |=> !opt_tx_out)
        else $error("transmitter lit during soft reset");

    AST_SRST_RESTORE: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(soft_rst)
        |-> (ctrl_q == LPC_CTRL_RST_VAL))
        else $error("control not restored after soft reset");

    AST_SRST_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(sublayer_soft_reset)
        |-> (srst_run_q == LPC_SRST_CYCLES))
        else $error("soft reset pin pulse length wrong");

    AST_IRQ_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        (|((ist_q | ev) & ien_q))
        |=> irq)
        else $error("irq low with an enabled status bit");

    AST_IRQ_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|((ist_q | ev) & ien_q))
        |=> !irq)
        else $error("irq high with no enabled status bit");

    AST_EV_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        (|ev)
        |=> (|ist_q))
        else $error("event lost by the sticky status");

    AST_SD_UP_EV: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(sd_q)
        |-> ev[LPC_EV_SIG_UP])
        else $error("signal detect rise not flagged");

    AST_SD_DN_EV: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(sd_q)
        |-> ev[LPC_EV_SIG_DN])
        else $error("signal detect fall not flagged");

    AST_NO_RST_EV: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(hresetn)
        |-> !ev[LPC_EV_RXFLT])
        else $error("false rx fault event after reset");
endmodule

//--- dv/lpc_fiber_model.sv
// far-side model: fiber loopback, optical comparator and fault sources
`timescale 1ns/1ns
module lpc_fiber_model (
    input  wire logic       hclk,
    input  wire logic       opt_tx_out,
    input  wire logic       light_on,
    input  wire logic [2:0] flt,
    output logic            opt_rx_in,
    output logic            sigdet_comp,
    output logic      [2:0] flt_impl
);
    logic noise_q = 1'b0;

    always @(posedge hclk) begin
        noise_q <= ~noise_q;
    end

    // a dark fiber shows a changing pattern, never the last bit sent
    assign opt_rx_in = light_on ? opt_tx_out : noise_q;
    // comparator: dark is below threshold, lit is above sensitivity, no pattern check
    assign sigdet_comp = light_on;
    assign flt_impl = flt;
endmodule

//--- dv/test_lrm_pmd_status_control.sv
// self-checking bench for the optical sublayer control block
`timescale 1ns/1ns
module test_lrm_pmd_status_control
    import lpc_pkg::*;
;
    typedef struct packed {
        logic       light;
        logic [2:0] flt;
        logic [2:0] ctrl;
        logic [4:0] st;
    } lpc_row_s;

    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, tx_bit, light;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, flt;
    logic        hreadyout, hresp, opt_tx_out, opt_rx_in, rx_bit;
    logic        sigdet_comp, signal_detect, sublayer_soft_reset, irq;
    wire  [2:0]  flt_impl;
    int          error_cnt = 0;
    int          checked = 0;
    int          n_rst, n_off;
    lpc_row_s    rows [7] = '{'{1'b1, 3'h0, 3'h4, 5'h01}, '{1'b0, 3'h0, 3'h4, 5'h0a},
                              '{1'b1, 3'h1, 3'h4, 5'h0b}, '{1'b1, 3'h2, 3'h4, 5'h1d},
                              '{1'b1, 3'h4, 3'h0, 5'h09}, '{1'b1, 3'h0, 3'h2, 5'h11},
                              '{1'b1, 3'h2, 3'h0, 5'h0d}};

    always #2 hclk = ~hclk;

    lpc_pmd_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tx_bit(tx_bit), .opt_tx_out(opt_tx_out),
        .opt_rx_in(opt_rx_in), .rx_bit(rx_bit), .sigdet_comp(sigdet_comp), .signal_detect(signal_detect),
        .tx_fault_impl(flt_impl[1]), .rx_fault_impl(flt_impl[0]), .other_fault_impl(flt_impl[2]),
        .sublayer_soft_reset(sublayer_soft_reset), .irq(irq));

    lpc_fiber_model far_end (.hclk(hclk), .opt_tx_out(opt_tx_out), .light_on(light), .flt(flt),
        .opt_rx_in(opt_rx_in), .sigdet_comp(sigdet_comp), .flt_impl(flt_impl));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_rdy();
        for (int n = 0; n < 64; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        error_cnt++;
        stop_test();
    endtask

    // one single word transfer; returns at the edge that ends its data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0000_00, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        q = hrdata;
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        tx_bit = 1'b0;
        light = 1'b0;
        flt = 3'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, LPC_OFF_CTRL, 32'h0000_0000, rd);
        chk("ctrl reset", rd, {29'h0000_000, LPC_CTRL_RST_VAL});
        bus(1'b0, LPC_OFF_IRQ_EN, 32'h0000_0000, rd);
        chk("irq_en reset", rd, 32'h0000_0000);
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, LPC_OFF_CTRL, {29'h0000_000, rows[i].ctrl}, rd);
            light <= rows[i].light;
            flt <= rows[i].flt;
            repeat (8) @(posedge hclk);
            bus(1'b0, LPC_OFF_STATUS, 32'h0000_0000, rd);
            chk("status", rd, {27'h0000_000, rows[i].st});
            bus(1'b0, LPC_OFF_IMPL, 32'h0000_0000, rd);
            chk("impl", rd, {29'h0000_000, rows[i].flt});
            chk("sigdet", {31'h0, signal_detect}, {31'h0, rows[i].light});
            for (int b = 1; b >= 0; b--) begin
                @(posedge hclk) tx_bit <= b[0];
                @(posedge hclk);
                #1;
                chk("opt_tx_out", {31'h0, opt_tx_out}, {31'h0, b[0] & ~rows[i].st[4]});
                @(posedge hclk);
                #1;
                if (rows[i].light) chk("rx_bit", {31'h0, rx_bit}, {31'h0, b[0] & ~rows[i].st[4]});
            end
            $display("test row %0d done", i);
        end
        @(posedge hclk);
        flt <= 3'h0;
        tx_bit <= 1'b1;
        repeat (8) @(posedge hclk);
        bus(1'b1, LPC_OFF_CTRL, 32'h0000_0005, rd);
        n_rst = 0;
        n_off = 0;
        repeat (20) begin
            @(posedge hclk);
            n_rst += (sublayer_soft_reset === 1'b1);
            n_off += (opt_tx_out === 1'b0);
        end
        chk("soft reset length", n_rst, {28'h0, LPC_SRST_CYCLES});
        chk("tx off in soft reset", {31'h0, n_off >= 8}, 32'h0000_0001);
        bus(1'b0, LPC_OFF_CTRL, 32'h0000_0000, rd);
        chk("ctrl after soft reset", rd, 32'h0000_0004);
        $display("test soft reset done");
        bus(1'b1, LPC_OFF_IRQ_CLR, 32'h0000_000f, rd);
        bus(1'b1, LPC_OFF_IRQ_EN, 32'h0000_0001, rd);
        bus(1'b0, LPC_OFF_IRQ_STAT, 32'h0000_0000, rd);
        chk("irq stat clear", rd, 32'h0000_0000);
        light <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        bus(1'b0, LPC_OFF_IRQ_STAT, 32'h0000_0000, rd);
        chk("irq stat fall", rd, 32'h0000_0006);
        light <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("irq raised", {31'h0, irq}, 32'h0000_0001);
        bus(1'b0, LPC_OFF_IRQ_STAT, 32'h0000_0000, rd);
        chk("irq stat rise", rd, 32'h0000_0007);
        bus(1'b1, LPC_OFF_IRQ_CLR, 32'h0000_0007, rd);
        bus(1'b0, LPC_OFF_IRQ_STAT, 32'h0000_0000, rd);
        chk("irq stat cleared", rd, 32'h0000_0000);
        chk("irq dropped", {31'h0, irq}, 32'h0000_0000);
        $display("test interrupt done");
        bus(1'b1, 8'h40, 32'hffff_ffff, rd);
        bus(1'b0, 8'h40, 32'h0000_0000, rd);
        chk("unmapped", rd, 32'h0000_0000);
        bus(1'b1, LPC_OFF_STATUS, 32'hffff_ffff, rd);
        bus(1'b0, LPC_OFF_STATUS, 32'h0000_0000, rd);
        chk("status read only", rd, 32'h0000_0001);
        chk("hresp okay", {31'h0, hresp}, 32'h0000_0000);
        chk("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
        $display("test bus map done");
        stop_test();
    end
endmodule
